// *** design/sdt_params.svh ***
// Constants of the SDR DRAM command and timing block
`ifndef SDT_PARAMS_SVH
`define SDT_PARAMS_SVH
`define SDT_CLK_NS 20
`define SDT_READ_LAT 2
`define SDT_AC_DELAY (`SDT_READ_LAT - 1)
`define SDT_T_REFI_NS 15600
`define SDT_REFI_CYC (`SDT_T_REFI_NS / `SDT_CLK_NS)
`define SDT_COL_W 8
`define SDT_ROW_W 11
`define SDT_IDX_W (`SDT_COL_W + 1)
`define SDT_AP_BIT 10
`define SDT_FIFO_DEPTH 32
`define SDT_BLEN_RST 4'h4
`endif

// *** design/sdt_pkg.sv ***
// Types shared by the SDR DRAM command and timing block
`include "sdt_params.svh"
package sdt_pkg;
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0, CMD_DESEL = 4'h1, CMD_HALT = 4'h2, CMD_READ = 4'h3,
        CMD_WRITE = 4'h4, CMD_ACT = 4'h5, CMD_PRE = 4'h6, CMD_REF = 4'h7,
        CMD_MODE = 4'h8
    } sdt_cmd_t;
    typedef enum logic [1:0] {PW_RUN = 2'h0, PW_DOWN = 2'h1, PW_SELF = 2'h2} sdt_pw_t;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bank;
        logic [10:0] addr;
    } sdt_pins_t;
    typedef struct packed {
        logic [`SDT_IDX_W-1:0] idx;
        logic [3:0] mask;
        logic [31:0] data;
    } sdt_wr_t;
endpackage

// *** design/sdt_dram.sv ***
// SDR DRAM device: command decode, bursts, latencies, refresh, write FIFO
`include "sdt_params.svh"

// ****************************************
// Write FIFO
// ****************************************
// DEPTH must be a power of two
module sdt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW:0] wp_reg;
    logic [AW:0] rp_reg;

    assign in_ready = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
    assign out_valid = wp_reg != rp_reg;
    assign out_data = store[rp_reg[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            store[wp_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp_reg <= rp_reg + 1'b1;
            end
        end
    end
endmodule // sdt_fifo

// ****************************************
// Device core
// ****************************************
// Contract
// - Device stops internal clocking one cycle after clock enable drops.
// - Byte mask raised during a read floats that byte two cycles later.
// - Write data and its byte mask are taken in the command cycle.
// - Burst halt or precharge during a read floats data two cycles later.
// - Column commands may follow each other on consecutive clocks.
// - Cycle after clock_suspend holds burst and read data, ignores write data.
// - write_autoclose starts precharge read_latency minus one after burst end.
// - Auto refresh ignores bank select and uses the internal row counter.
module sdt_dram import sdt_pkg::*; #(
    parameter int FIFO_DEPTH = `SDT_FIFO_DEPTH,
    parameter int REFI_CYC = `SDT_REFI_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire sdt_pins_t cmd_pins,
    input wire logic clk_en,
    input wire logic [3:0] byte_mask,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out,
    output logic [3:0] dq_oe,
    output logic [1:0] bank_open,
    output logic [`SDT_ROW_W-1:0] refresh_row,
    output sdt_pw_t power_state,
    output logic wr_full
);
    localparam int MEM_N = 1 << `SDT_IDX_W;
    localparam logic [1:0] AC_DELAY = 2'(`SDT_AC_DELAY);

    sdt_cmd_t cmd;
    logic cke_q_reg;
    logic cmd_ok;
    logic stop;
    logic beat_v, beat_wr, beat_ap, beat_last, beat_bank;
    logic [`SDT_COL_W-1:0] beat_col;
    logic [`SDT_IDX_W-1:0] cmd_idx;
    logic [3:0] blen_reg;
    logic [3:0] brst_left_reg;
    logic [`SDT_COL_W-1:0] brst_col_reg;
    logic brst_bank_reg, brst_wr_reg, brst_ap_reg;
    logic ac_v_reg, ac_bank_reg, ac_fire;
    logic [1:0] ac_cnt_reg;
    logic [11:0] refi_cnt_reg;
    logic self_tick;
    logic p0_v_reg, p1_v_reg;
    logic [`SDT_IDX_W-1:0] p0_idx_reg;
    logic [3:0] p0_mask_reg, p1_mask_reg;
    logic [31:0] p1_data;
    logic fifo_push, fifo_in_ready, drain_v, drain_rdy;
    sdt_wr_t push_data, drain_data;

    // ****************************************
    // Command decode
    // ****************************************
    always_comb begin
        cmd = CMD_NOP;
        if (cmd_pins.cs_n) begin
            cmd = CMD_DESEL;
        end else begin
            case ({cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n})
                3'h6: cmd = CMD_HALT;
                3'h5: cmd = CMD_READ;
                3'h4: cmd = CMD_WRITE;
                3'h3: cmd = CMD_ACT;
                3'h2: cmd = CMD_PRE;
                3'h1: cmd = CMD_REF;
                3'h0: cmd = CMD_MODE;
                default: cmd = CMD_NOP;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cke_q_reg <= 1'b0;
        end else begin
            cke_q_reg <= clk_en;
        end
    end

    assign cmd_ok = cke_q_reg && (power_state == PW_RUN);
    assign cmd_idx = {cmd_pins.bank, cmd_pins.addr[`SDT_COL_W-1:0]};
    assign stop = cmd_ok && ((cmd == CMD_HALT) || ((cmd == CMD_PRE)
                  && (cmd_pins.addr[`SDT_AP_BIT] || (cmd_pins.bank == brst_bank_reg))));

    // ****************************************
    // Burst engine
    // ****************************************
    always_comb begin
        beat_v = 1'b0;
        beat_wr = brst_wr_reg;
        beat_ap = brst_ap_reg;
        beat_bank = brst_bank_reg;
        beat_col = brst_col_reg;
        beat_last = brst_left_reg == 4'h1;
        // a new column command restarts at once
        if (cmd_ok && ((cmd == CMD_READ) || (cmd == CMD_WRITE))) begin
            beat_v = 1'b1;
            beat_wr = cmd == CMD_WRITE;
            beat_ap = cmd_pins.addr[`SDT_AP_BIT];
            beat_bank = cmd_pins.bank;
            beat_col = cmd_pins.addr[`SDT_COL_W-1:0];
            beat_last = blen_reg == 4'h1;
        end else if (cke_q_reg && (brst_left_reg != 4'h0) && !stop) begin
            beat_v = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            brst_left_reg <= 4'h0;
            brst_col_reg <= '0;
            brst_bank_reg <= 1'b0;
            brst_wr_reg <= 1'b0;
            brst_ap_reg <= 1'b0;
        end else if (cke_q_reg) begin
            if (cmd_ok && ((cmd == CMD_READ) || (cmd == CMD_WRITE))) begin
                brst_left_reg <= blen_reg - 4'h1;
                brst_col_reg <= beat_col + 1'b1;
                brst_bank_reg <= beat_bank;
                brst_wr_reg <= beat_wr;
                brst_ap_reg <= beat_ap;
            end else if (stop) begin
                brst_left_reg <= 4'h0;
            end else if (beat_v) begin
                brst_left_reg <= brst_left_reg - 4'h1;
                brst_col_reg <= brst_col_reg + 1'b1;
            end
        end
    end

    // Full-column bursts are not modelled; larger codes give eight beats
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            blen_reg <= `SDT_BLEN_RST;
        end else if (cmd_ok && (cmd == CMD_MODE)) begin
            case (cmd_pins.addr[1:0])
                2'h0: blen_reg <= 4'h1;
                2'h1: blen_reg <= 4'h2;
                2'h2: blen_reg <= 4'h4;
                default: blen_reg <= 4'h8;
            endcase
        end
    end

    // ****************************************
    // Banks and auto-precharge
    // ****************************************
    // precharge follows burst end by a fixed delay, mask or not
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ac_v_reg <= 1'b0;
            ac_cnt_reg <= 2'h0;
            ac_bank_reg <= 1'b0;
        end else if (cke_q_reg) begin
            if (beat_v && beat_last && beat_ap) begin
                ac_v_reg <= 1'b1;
                ac_cnt_reg <= AC_DELAY;
                ac_bank_reg <= beat_bank;
            end else if (ac_fire) begin
                ac_v_reg <= 1'b0;
            end else if (ac_v_reg) begin
                ac_cnt_reg <= ac_cnt_reg - 2'h1;
            end
        end
    end
    assign ac_fire = cke_q_reg && ac_v_reg && (ac_cnt_reg <= 2'h1);

    for (genvar b = 0; b < 2; b++) begin : g_bank
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                bank_open[b] <= 1'b0;
            end else if (cmd_ok && (cmd == CMD_ACT) && (cmd_pins.bank == 1'(b))) begin
                bank_open[b] <= 1'b1;
            end else if ((cmd_ok && (cmd == CMD_PRE) && (cmd_pins.addr[`SDT_AP_BIT]
                         || (cmd_pins.bank == 1'(b)))) || (ac_fire && (ac_bank_reg == 1'(b)))) begin
                bank_open[b] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Refresh and power states
    // ****************************************
    assign self_tick = (power_state == PW_SELF) && (refi_cnt_reg == 12'(REFI_CYC - 1));

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            refi_cnt_reg <= 12'h0;
        end else if ((power_state != PW_SELF) || self_tick) begin
            refi_cnt_reg <= 12'h0;
        end else begin
            refi_cnt_reg <= refi_cnt_reg + 12'h1;
        end
    end

    // row comes from the counter only; bank select is ignored
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            refresh_row <= '0;
        end else if ((cmd_ok && (cmd == CMD_REF)) || self_tick) begin
            refresh_row <= refresh_row + 1'b1;
        end
    end

    // enable low while busy suspends; while idle it powers down
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            power_state <= PW_RUN;
        end else begin
            case (power_state)
                PW_RUN: begin
                    if (cmd_ok && (cmd == CMD_REF) && !clk_en) begin
                        power_state <= PW_SELF;
                    end else if (cke_q_reg && !clk_en && !beat_v && (brst_left_reg == 4'h0)) begin
                        power_state <= PW_DOWN;
                    end
                end
                PW_DOWN, PW_SELF: begin
                    if (clk_en) begin
                        power_state <= PW_RUN;
                    end
                end
                default: power_state <= PW_RUN;
            endcase
        end
    end

    // ****************************************
    // Write path and array
    // ****************************************
    // data and mask taken with the beat; suspended beats dropped
    assign fifo_push = beat_v && beat_wr;
    assign push_data = '{idx: {beat_bank, beat_col}, mask: byte_mask, data: dq_in};
    // Array is single ported: reads win, queued writes wait
    assign drain_rdy = !(cke_q_reg && p0_v_reg);

    sdt_fifo #(.WIDTH($bits(sdt_wr_t)), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(fifo_push),
        .in_data(push_data),
        .in_ready(fifo_in_ready),
        .out_valid(drain_v),
        .out_ready(drain_rdy),
        .out_data(drain_data)
    );

    // Row bits are not stored; a read may miss a still-queued write
    for (genvar l = 0; l < 4; l++) begin : g_lane
        logic [7:0] lane_mem [0:MEM_N-1];
        always_ff @(posedge clk_sys) begin
            if (drain_v && drain_rdy && !drain_data.mask[l]) begin
                lane_mem[drain_data.idx] <= drain_data.data[8*l +: 8];
            end
            if (cke_q_reg) begin
                p1_data[8*l +: 8] <= lane_mem[p0_idx_reg];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_full <= 1'b0;
        end else begin
            wr_full <= !fifo_in_ready;
        end
    end

    // ****************************************
    // Read pipeline
    // ****************************************
    // mask rides with the beat to the drive stage
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            p0_v_reg <= 1'b0;
            p0_idx_reg <= '0;
            p0_mask_reg <= 4'h0;
            p1_v_reg <= 1'b0;
            p1_mask_reg <= 4'h0;
            dq_oe <= 4'h0;
            dq_out <= 32'h0;
        end else if (cke_q_reg) begin
            p0_v_reg <= beat_v && !beat_wr;
            p0_idx_reg <= {beat_bank, beat_col};
            p0_mask_reg <= byte_mask;
            p1_v_reg <= p0_v_reg;
            p1_mask_reg <= p0_mask_reg;
            dq_oe <= {4{p1_v_reg}} & ~p1_mask_reg;
            dq_out <= p1_data;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_cke_stops_clock: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !clk_en |=> ##1 ($stable(brst_left_reg) && $stable(dq_oe)))
        else $error("internal state moved after clock enable dropped");

    a_mask_floats_byte: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (cke_q_reg && beat_v && !beat_wr && byte_mask[0]) ##1 cke_q_reg ##1 cke_q_reg
        |=> !dq_oe[0])
        else $error("masked read byte still driven");

    a_read_drives_byte: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (cke_q_reg && beat_v && !beat_wr && !byte_mask[1]) ##1 cke_q_reg ##1 cke_q_reg
        |=> dq_oe[1])
        else $error("read byte not driven at read latency");

    a_write_same_cycle: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (cmd_ok && (cmd == CMD_WRITE) && fifo_in_ready)
        |-> (fifo_push && (push_data.data == dq_in) && (push_data.mask == byte_mask)))
        else $error("write data not taken with its command");

    a_halt_releases_bus: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (cmd_ok && (cmd == CMD_HALT)) ##1 cke_q_reg ##1 cke_q_reg |=> (dq_oe == 4'h0))
        else $error("data lines still driven two cycles after burst halt");

    a_back_to_back: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (cmd_ok && (cmd == CMD_READ)) ##1 (cmd_ok && (cmd == CMD_READ))
        |=> (p0_v_reg && (p0_idx_reg == $past(cmd_idx))))
        else $error("second consecutive read not started");

    a_suspend_no_write: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !cke_q_reg |-> !fifo_push)
        else $error("write data taken in a suspended cycle");

    a_autoclose_delay: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (cke_q_reg && beat_v && beat_last && beat_ap && beat_wr) ##1
        (cke_q_reg && !(cmd_ok && (cmd == CMD_ACT))) |=> !bank_open[ac_bank_reg])
        else $error("auto-precharge not started after burst end");

    a_refresh_counter: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (cmd_ok && (cmd == CMD_REF))
        |=> ((refresh_row - $past(refresh_row)) == 11'h1) && $stable(bank_open))
        else $error("refresh did not use the internal counter");

    a_cmd_needs_cke: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (!cke_q_reg && (cmd == CMD_ACT)) |=> $stable(bank_open))
        else $error("command accepted with clock enable low");
endmodule // sdt_dram

// *** testbench/sdt_ctrl_model.sv ***
// Memory controller model: spaces commands and drives the pins on falling edges
module sdt_ctrl_model import sdt_pkg::*; #(
    parameter int CLK_NS = 20
) (
    input wire logic clk_sys,
    output sdt_pins_t cmd_pins,
    output logic clk_en,
    output logic [3:0] byte_mask,
    output logic [31:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        sdt_pins_t pins;
        logic cke;
        logic [3:0] mask;
        logic [31:0] data;
    } sdt_beat_t;
    // ****************************************
    // Spacing in whole clocks, slower grade
    // ****************************************
    // round up
    localparam int T_RCD = (36 + CLK_NS - 1) / CLK_NS;
    localparam int T_RP = (36 + CLK_NS - 1) / CLK_NS;
    localparam int T_RAS = (72 + CLK_NS - 1) / CLK_NS;
    localparam int T_RSC = (36 + CLK_NS - 1) / CLK_NS;
    localparam int T_DPL = (18 + CLK_NS - 1) / CLK_NS;
    localparam int T_RC = T_RAS + T_RP;
    // turnaround: eight beats, two-cycle latency, two clear clocks
    localparam int RD_TURN = 12;
    localparam sdt_pins_t NOP = 16'h7000;
    sdt_beat_t beats[$];
    sdt_beat_t b;
    int slot = 0;
    int ready_at = 0;
    int wr_ok_at = 0;

    // refresh interval: runs end long before one interval, so none is owed
    function automatic int need(input sdt_pins_t p, input int n);
        case ({p.ras_n, p.cas_n, p.we_n})
            3'b011: return T_RCD;
            3'b100: return p.addr[10] ? n + T_RP : n - 1 + T_DPL;
            3'b001: return T_RC;
            3'b000: return T_RSC;
            3'b010: return T_RP;
            // read autoclose: longest burst plus precharge
            3'b101: return p.addr[10] ? 8 + T_RP : 1;
            default: return 1;
        endcase
    endfunction

    // ****************************************
    // Pin driver
    // ****************************************
    initial begin
        cmd_pins = NOP;
        clk_en = 1'b1;
        byte_mask = 4'h0;
        dq_in = 32'h0;
    end

    // Idle slots keep clock enable; released data lines never repeat the last word
    always @(negedge clk_sys) begin
        if (beats.size() > 0) begin
            b = beats.pop_front();
            cmd_pins = b.pins;
            clk_en = b.cke;
            byte_mask = b.mask;
            dq_in = b.data;
        end else begin
            cmd_pins = NOP;
            byte_mask = 4'h0;
            dq_in = ~dq_in;
        end
        slot = slot + 1;
    end

    // Returns just after the edge that takes the last beat
    task automatic xfer(input sdt_pins_t p, input int n, input logic cke,
                        input logic [31:0] w [4], input logic [3:0] m [4]);
        int first;
        int gate;
        first = slot + beats.size();
        gate = ready_at;
        // a write waits out the read turnaround
        if (({p.ras_n, p.cas_n, p.we_n} == 3'b100) && (wr_ok_at > gate)) begin
            gate = wr_ok_at;
        end
        while (first < gate) begin
            beats.push_back({NOP, clk_en, 4'h0, ~dq_in});
            first++;
        end
        for (int k = 0; k < n; k++) begin
            beats.push_back({(k == 0) ? p : NOP, cke, m[k], w[k]});
        end
        ready_at = first + need(p, n);
        if ({p.ras_n, p.cas_n, p.we_n} == 3'b101) begin
            wr_ok_at = first + RD_TURN;
        end
        while (beats.size() > 0) @(posedge clk_sys);
        #1;
    endtask
endmodule // sdt_ctrl_model

// *** testbench/sdt_dram_bench.sv ***
// Self-checking testbench for the SDR DRAM device block
module sdt_dram_bench import sdt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REFI = 8;
    localparam logic [2:0] OP_RD = 3'h5, OP_WR = 3'h4, OP_ACT = 3'h3, OP_PRE = 3'h2;
    localparam logic [2:0] OP_REF = 3'h1, OP_MODE = 3'h0, OP_HALT = 3'h6, OP_NOP = 3'h7;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    sdt_pins_t cmd_pins;
    logic clk_en;
    logic [3:0] byte_mask;
    logic [31:0] dq_in;
    logic [31:0] dq_out;
    logic [3:0] dq_oe;
    logic [1:0] bank_open;
    logic [10:0] refresh_row;
    sdt_pw_t power_state;
    logic wr_full;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] wa [4];
    logic [3:0] ma [4];
    logic [10:0] r;

    sdt_dram #(.FIFO_DEPTH(32), .REFI_CYC(REFI)) i_sdt_dram (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .cmd_pins(cmd_pins), .clk_en(clk_en), .byte_mask(byte_mask),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open),
        .refresh_row(refresh_row), .power_state(power_state), .wr_full(wr_full));
    sdt_ctrl_model #(.CLK_NS(20)) i_sdt_ctrl_model (.clk_sys(clk_sys), .cmd_pins(cmd_pins),
        .clk_en(clk_en), .byte_mask(byte_mask), .dq_in(dq_in));

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic go(input logic [2:0] op, input logic bk, input logic [10:0] a,
                      input int n, input logic cke);
        i_sdt_ctrl_model.xfer({1'b0, op, bk, a}, n, cke, wa, ma);
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk("bank_open", 32'h0, bank_open);
        chk("dq_oe", 32'h0, dq_oe);
        chk("power_state", PW_RUN, power_state);
        chk("refresh_row", 32'h0, refresh_row);
        chk("wr_full", 32'h0, wr_full);
        $display("t_reset finished");
    endtask

    task automatic t_write_read();
        for (int k = 0; k < 4; k++) begin
            wa[k] = 32'h5a5a0000 | k;
            ma[k] = 4'h0;
        end
        go(OP_MODE, 1'b0, 11'h002, 1, 1'b1);
        go(OP_ACT, 1'b0, 11'h005, 1, 1'b1);
        chk("bank_open act", 32'h1, bank_open);
        go(OP_WR, 1'b0, 11'h008, 4, 1'b1);
        chk("wr_full", 32'h0, wr_full);
        for (int k = 0; k < 4; k++) begin
            wa[k] = 32'ha5a5ff10 | k;
            ma[k] = 4'hf;
        end
        ma[0] = 4'he;
        go(OP_WR, 1'b0, 11'h008, 4, 1'b1);
        ma[0] = 4'h0;
        ma[1] = 4'h0;
        ma[2] = 4'h0;
        ma[3] = 4'h0;
        tk(4);
        go(OP_RD, 1'b0, 11'h008, 1, 1'b1);
        go(OP_RD, 1'b0, 11'h00a, 1, 1'b1);
        tk(1);
        chk("col 8", 32'h5a5a0010, dq_out);
        chk("oe beat 0", 32'hf, dq_oe);
        tk(1);
        chk("col 10", 32'h5a5a0002, dq_out);
        tk(1);
        chk("col 11", 32'h5a5a0003, dq_out);
        $display("t_write_read finished");
    endtask

    task automatic t_read_mask();
        tk(4);
        ma[1] = 4'h3;
        go(OP_RD, 1'b0, 11'h008, 2, 1'b1);
        ma[1] = 4'h0;
        tk(1);
        chk("oe before mask", 32'hf, dq_oe);
        tk(1);
        chk("oe masked", 32'hc, dq_oe);
        tk(1);
        chk("oe after mask", 32'hf, dq_oe);
        $display("t_read_mask finished");
    endtask

    task automatic t_halt();
        for (int i = 0; i < 2; i++) begin
            tk(4);
            go(OP_RD, 1'b0, 11'h008, 1, 1'b1);
            go((i == 0) ? OP_HALT : OP_PRE, 1'b0, 11'h000, 1, 1'b1);
            tk(1);
            chk("oe after stop", 32'hf, dq_oe);
            tk(1);
            chk("oe floated", 32'h0, dq_oe);
        end
        chk("bank closed", 32'h0, bank_open);
        $display("t_halt finished");
    endtask

    task automatic t_suspend();
        go(OP_ACT, 1'b0, 11'h005, 1, 1'b1);
        go(OP_RD, 1'b0, 11'h008, 1, 1'b1);
        go(OP_NOP, 1'b0, 11'h000, 1, 1'b1);
        go(OP_NOP, 1'b0, 11'h000, 1, 1'b0);
        go(OP_NOP, 1'b0, 11'h000, 1, 1'b1);
        chk("held word", 32'h5a5a0010, dq_out);
        chk("held oe", 32'hf, dq_oe);
        tk(1);
        chk("next word", 32'h5a5a0001, dq_out);
        $display("t_suspend finished");
    endtask

    task automatic t_autoclose();
        tk(4);
        go(OP_WR, 1'b0, 11'h400, 4, 1'b1);
        chk("open at last beat", 32'h1, bank_open);
        tk(1);
        chk("closed after burst", 32'h0, bank_open);
        $display("t_autoclose finished");
    endtask

    task automatic t_refresh();
        go(OP_ACT, 1'b1, 11'h005, 1, 1'b1);
        // Row active time before the close
        tk(3);
        go(OP_PRE, 1'b0, 11'h400, 1, 1'b1);
        chk("all closed", 32'h0, bank_open);
        r = refresh_row;
        go(OP_REF, 1'b1, 11'h000, 1, 1'b1);
        chk("row counter", r + 32'h1, refresh_row);
        chk("banks untouched", 32'h0, bank_open);
        go(OP_REF, 1'b0, 11'h000, 1, 1'b1);
        chk("row counter 2", r + 32'h2, refresh_row);
        $display("t_refresh finished");
    endtask

    task automatic t_short_burst();
        // banks closed, lines floating; code 1 gives two beats
        go(OP_MODE, 1'b0, 11'h001, 1, 1'b1);
        go(OP_ACT, 1'b1, 11'h005, 1, 1'b1);
        go(OP_RD, 1'b1, 11'h400, 1, 1'b1);
        tk(1);
        chk("open at last read beat", 32'h2, bank_open);
        tk(1);
        chk("read autoclosed", 32'h0, bank_open);
        chk("short burst oe", 32'hf, dq_oe);
        tk(1);
        chk("second beat oe", 32'hf, dq_oe);
        tk(1);
        chk("two beats only", 32'h0, dq_oe);
        $display("t_short_burst finished");
    endtask

    task automatic t_power();
        go(OP_NOP, 1'b0, 11'h000, 1, 1'b0);
        chk("power down", PW_DOWN, power_state);
        go(OP_ACT, 1'b0, 11'h005, 1, 1'b0);
        chk("refused act", 32'h0, bank_open);
        go(OP_NOP, 1'b0, 11'h000, 1, 1'b1);
        chk("power up", PW_RUN, power_state);
        tk(1);
        go(OP_REF, 1'b0, 11'h000, 1, 1'b0);
        chk("self refresh", PW_SELF, power_state);
        r = refresh_row;
        tk(2 * REFI + 2);
        chk("rows advance", 32'h1, refresh_row != r);
        go(OP_NOP, 1'b0, 11'h000, 1, 1'b1);
        chk("self exit", PW_RUN, power_state);
        $display("t_power finished");
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        tk(2);
        t_reset();
        t_write_read();
        t_read_mask();
        t_halt();
        t_suspend();
        t_autoclose();
        t_refresh();
        t_short_burst();
        t_power();
        wrap_up();
    end

    // The tests take about 140 clocks; a hang is cut off well beyond that
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        $display("Error watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule // sdt_dram_bench
